// ---- rtl/ssf_pkg.sv ----
// Package of constants and types for the sample status flag block
package ssf_pkg;

    // ==========================================
    // Register addresses
    localparam logic [7:0] SSF_ADDR_ALIAS     = 8'h00;
    localparam logic [7:0] SSF_ADDR_PRESS_HI  = 8'h01;
    localparam logic [7:0] SSF_ADDR_TEMP_HI   = 8'h04;
    localparam logic [7:0] SSF_ADDR_STATUS    = 8'h06;
    localparam logic [7:0] SSF_ADDR_FIFO_STAT = 8'h0D;
    localparam logic [7:0] SSF_ADDR_FIFO_DATA = 8'h0E;

    // ==========================================
    // Status bit positions and reset value
    localparam int SSF_BIT_ANY_OW   = 7;
    localparam int SSF_BIT_PRESS_OW = 6;
    localparam int SSF_BIT_TEMP_OW  = 5;
    localparam int SSF_BIT_ANY_RDY  = 3;
    localparam int SSF_BIT_PRESS_RDY = 2;
    localparam int SSF_BIT_TEMP_RDY = 1;
    localparam logic [7:0] SSF_STATUS_RESET = 8'h00;

    // ==========================================
    // FIFO mode encodings
    typedef enum logic [1:0] {
        SSF_FIFO_OFF      = 2'b00,
        SSF_FIFO_CIRCULAR = 2'b01,
        SSF_FIFO_STOP     = 2'b10,
        SSF_FIFO_RSVD     = 2'b11
    } ssf_fifo_mode_type;

    // ==========================================
    // Event enables from the data configuration register
    typedef struct packed {
        logic ready_event_gen_enable;
        logic press_event_gen_enable;
        logic temp_event_gen_enable;
    } ssf_event_cfg_type;

    // Register read request from the serial port
    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
    } ssf_read_req_type;

endpackage

// ---- rtl/ssf_flag_cell.sv ----
// One sticky status flag with set priority over clear
`timescale 1ns/1ps
module ssf_flag_cell
    import ssf_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Control
    input  wire logic set_i,
    input  wire logic clear_i,
    // Flag
    output logic      flag_o
);

    logic flag_r;
    logic flag_nxt;

    // Set wins over a clear in the same cycle
    always_comb begin
        flag_nxt = flag_r;
        if (clear_i) begin
            flag_nxt = 1'b0;
        end
        if (set_i) begin
            flag_nxt = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;

endmodule

// ---- rtl/ssf_alias_mux.sv ----
// Address alias and read data selection for the status registers
`timescale 1ns/1ps
module ssf_alias_mux
    import ssf_pkg::*;
(
    // Request
    input  wire logic [7:0]        addr_i,
    input  wire ssf_fifo_mode_type fifo_mode_i,
    // Sources
    input  wire logic [7:0]        sample_status_i,
    input  wire logic [7:0]        fifo_status_i,
    // Result
    output logic      [7:0]        rdata_o,
    output logic                   hit_o
);

    logic [7:0] eff_addr;

    // Alias address zero by FIFO mode
    always_comb begin
        eff_addr = addr_i;
        if (addr_i == SSF_ADDR_ALIAS) begin
            eff_addr = (fifo_mode_i == SSF_FIFO_OFF) ? SSF_ADDR_STATUS : SSF_ADDR_FIFO_STAT;
        end
    end

    // Read data for the two owned registers
    always_comb begin
        rdata_o = 8'h00;
        hit_o   = 1'b0;
        if (eff_addr == SSF_ADDR_STATUS) begin
            rdata_o = sample_status_i;
            hit_o   = 1'b1;
        end else if (eff_addr == SSF_ADDR_FIFO_STAT) begin
            rdata_o = fifo_status_i;
            hit_o   = 1'b1;
        end
    end

endmodule

// ---- rtl/ssf_status.sv ----
// Sample status flag register with address alias and read-clear logic
// ==========================================
// Timing and usage notes
// A read strobe is taken on a rising edge and answered one
// cycle later on rdata_o, with a one-cycle rvalid_o pulse.
// The answer shows the flags as they stood before the clear
// caused by that same read, so a status read followed by a
// data read never loses an event in between.
// sample_status_o is a registered copy of the flag cells and
// lags them by one cycle; it is meant for observation only.
// Only the status byte and the FIFO status byte answer with
// data here; every other address reads back 00h from this
// block and is merged with the data path outside it.
// FIFO mode 11 is not a defined setting; it is handled as a
// FIFO mode, so only FIFO data port reads clear flags then.
// A completion and a clearing read in the same cycle leave
// the ready flag set; no overwrite is raised in that case,
// because the host has just fetched the older sample.
// The combined flags follow only the ready event enable,
// the per-channel flags only their own channel enable.
// Changing the FIFO mode leaves the flags as they are; only
// the source of the clearing reads and the target of address 00h change with it.
// Done pulses must be one cycle wide: a longer pulse counts
// as several acquisitions and raises the overwrite flags.
// All inputs but rst_i are taken as synchronous to clock_i; the FIFO
// status byte is sampled at the edge that takes the strobe.
`timescale 1ns/1ps
module ssf_status
    import ssf_pkg::*;
(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // Configuration
    input  wire ssf_fifo_mode_type fifo_mode_i,
    input  wire ssf_event_cfg_type event_cfg_i,
    // Acquisition completion pulses
    input  wire logic              press_done_i,
    input  wire logic              temp_done_i,
    // Register read port
    input  wire ssf_read_req_type  read_req_i,
    input  wire logic [7:0]        fifo_status_i,
    // Read answer, one cycle after the strobe
    output logic      [7:0]        rdata_o,
    output logic                   rvalid_o,
    // Registered status copy, one cycle behind the flags
    output logic      [7:0]        sample_status_o
);

    // ==========================================
    // Decode of clearing reads
    logic fifo_on;
    logic rd_press_hi;
    logic rd_temp_hi;
    logic rd_fifo_data;
    logic clr_press;
    logic clr_temp;
    logic clr_any;

    assign fifo_on      = (fifo_mode_i != SSF_FIFO_OFF);
    assign rd_press_hi  = read_req_i.strobe && (read_req_i.addr == SSF_ADDR_PRESS_HI);
    assign rd_temp_hi   = read_req_i.strobe && (read_req_i.addr == SSF_ADDR_TEMP_HI);
    assign rd_fifo_data = read_req_i.strobe && (read_req_i.addr == SSF_ADDR_FIFO_DATA);

    // Clear sources by FIFO mode
    always_comb begin
        if (fifo_on) begin
            clr_press = rd_fifo_data;
            clr_temp  = rd_fifo_data;
            clr_any   = rd_fifo_data;
        end else begin
            clr_press = rd_press_hi;
            clr_temp  = rd_temp_hi;
            clr_any   = rd_press_hi | rd_temp_hi;
        end
    end

    // ==========================================
    // Set conditions
    logic press_rdy;
    logic temp_rdy;
    logic any_rdy;
    logic set_press_rdy;
    logic set_temp_rdy;
    logic set_press_ow;
    logic set_temp_ow;
    logic set_any_rdy;
    logic set_any_ow;

    // Event gating and overwrite detection
    always_comb begin
        set_press_rdy = press_done_i & event_cfg_i.press_event_gen_enable;
        set_temp_rdy  = temp_done_i & event_cfg_i.temp_event_gen_enable;
        set_press_ow  = set_press_rdy & press_rdy & ~clr_press;
        set_temp_ow   = set_temp_rdy & temp_rdy & ~clr_temp;
        set_any_rdy   = (press_done_i | temp_done_i) & event_cfg_i.ready_event_gen_enable;
        set_any_ow    = set_any_rdy & any_rdy & ~clr_any;
    end

    // ==========================================
    // Six flag cells, set priority inside
    logic any_ow;
    logic press_ow;
    logic temp_ow;

    ssf_flag_cell u_any_ow_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (set_any_ow),
        .clear_i (clr_any),
        .flag_o  (any_ow)
    );

    ssf_flag_cell u_press_ow_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (set_press_ow),
        .clear_i (clr_press),
        .flag_o  (press_ow)
    );

    ssf_flag_cell u_temp_ow_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (set_temp_ow),
        .clear_i (clr_temp),
        .flag_o  (temp_ow)
    );

    ssf_flag_cell u_any_rdy_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (set_any_rdy),
        .clear_i (clr_any),
        .flag_o  (any_rdy)
    );

    ssf_flag_cell u_press_rdy_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (set_press_rdy),
        .clear_i (clr_press),
        .flag_o  (press_rdy)
    );

    ssf_flag_cell u_temp_rdy_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (set_temp_rdy),
        .clear_i (clr_temp),
        .flag_o  (temp_rdy)
    );

    // ==========================================
    // Status byte assembly
    logic [7:0] status_now;

    always_comb begin
        status_now                    = SSF_STATUS_RESET;
        status_now[SSF_BIT_ANY_OW]    = any_ow;
        status_now[SSF_BIT_PRESS_OW]  = press_ow;
        status_now[SSF_BIT_TEMP_OW]   = temp_ow;
        status_now[SSF_BIT_ANY_RDY]   = any_rdy;
        status_now[SSF_BIT_PRESS_RDY] = press_rdy;
        status_now[SSF_BIT_TEMP_RDY]  = temp_rdy;
    end

    // ==========================================
    // Read data path
    logic [7:0] mux_data;
    logic       mux_hit;

    ssf_alias_mux u_alias (
        .addr_i          (read_req_i.addr),
        .fifo_mode_i     (fifo_mode_i),
        .sample_status_i (status_now),
        .fifo_status_i   (fifo_status_i),
        .rdata_o         (mux_data),
        .hit_o           (mux_hit)
    );

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;

    // Next read answer and status copy
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = read_req_i.strobe;
        status_nxt = status_now;
        if (read_req_i.strobe) begin
            // Value before any clear by this read
            rdata_nxt = mux_hit ? mux_data : 8'h00;
        end
    end

    // Output registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            status_r <= SSF_STATUS_RESET;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            status_r <= status_nxt;
        end
    end

    assign rdata_o         = rdata_r;
    assign rvalid_o        = rvalid_r;
    assign sample_status_o = status_r;

endmodule

// ---- testbench/ssf_status_sva.sv ----
// Assertion checker for the status flag block
`timescale 1ns/1ps
module ssf_status_sva
    import ssf_pkg::*;
(
    // Clock and reset
    input wire logic              clock_i,
    input wire logic              rst_i,
    // Inputs
    input wire ssf_fifo_mode_type fifo_mode_i,
    input wire ssf_event_cfg_type event_cfg_i,
    input wire logic              press_done_i,
    input wire logic              temp_done_i,
    input wire ssf_read_req_type  read_req_i,
    input wire logic [7:0]        fifo_status_i,
    // Outputs
    input wire logic [7:0]        rdata_o,
    input wire logic              rvalid_o,
    input wire logic [7:0]        sample_status_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Decode helpers
    wire logic       off = (fifo_mode_i == SSF_FIFO_OFF);
    wire logic       rs  = read_req_i.strobe;
    wire logic [7:0] ra  = read_req_i.addr;
    wire logic       nd  = !press_done_i && !temp_done_i;
    wire logic [7:0] st  = sample_status_o;
    property p_al0;
        rs && ra == 8'h00 && off |=> rvalid_o && rdata_o == st;
    endproperty
    a_al0: assert property (p_al0) else $error("alias off");
    property p_al1;
        rs && ra == 8'h00 && !off |=> rdata_o == $past(fifo_status_i);
    endproperty
    a_al1: assert property (p_al1) else $error("alias on");
    property p_rsv;
        st[4] == 1'b0 && st[0] == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_prdy;
        press_done_i && event_cfg_i.press_event_gen_enable |-> ##2 st[2];
    endproperty
    a_prdy: assert property (p_prdy) else $error("press ready");
    property p_any;
        !nd && event_cfg_i.ready_event_gen_enable |-> ##2 st[3];
    endproperty
    a_any: assert property (p_any) else $error("any ready");
    property p_pen;
        $rose(st[2]) |-> $past(event_cfg_i.press_event_gen_enable, 2);
    endproperty
    a_pen: assert property (p_pen) else $error("press enable");
    property p_fclr;
        rs && ra == 8'h0E && !off && nd |-> ##2 st == 8'h00;
    endproperty
    a_fclr: assert property (p_fclr) else $error("fifo clear");
    property p_tclr;
        rs && ra == 8'h04 && off && nd |-> ##2 (st & 8'hAA) == 8'h00;
    endproperty
    a_tclr: assert property (p_tclr) else $error("temp clear");
    // Main scenarios
    c_rd: cover property (rvalid_o);
    c_ow: cover property (st[7] && st[6]);
    c_fifo: cover property (rs && !off);
    c_ovl: cover property (press_done_i && rs && ra == 8'h01 && off);
endmodule
bind ssf_status ssf_status_sva u_sva (.clock_i(clock_i), .rst_i(rst_i),
    .fifo_mode_i(fifo_mode_i), .event_cfg_i(event_cfg_i),
    .press_done_i(press_done_i), .temp_done_i(temp_done_i),
    .read_req_i(read_req_i), .fifo_status_i(fifo_status_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sample_status_o(sample_status_o));

// ---- testbench/ssf_host_model.sv ----
// Host model issuing single-byte register reads
`timescale 1ns/1ps
module ssf_host_model
    import ssf_pkg::*;
(
    // Clock
    input  wire logic        clock_i,
    // Read request
    output ssf_read_req_type read_req_o
);
    initial read_req_o = '0;
    // One byte read, entered at a falling edge
    task automatic read_byte(logic [7:0] a);
        read_req_o = {1'b1, a};
        @(negedge clock_i);
        read_req_o = {1'b0, ~a};
    endtask
endmodule

// ---- testbench/tb_ssf_status.sv ----
// Bench for the status flag block
`timescale 1ns/1ps
module tb_ssf_status;
    import ssf_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    ssf_fifo_mode_type md = SSF_FIFO_OFF;
    ssf_event_cfg_type cfg = 3'h7;
    logic pd = 1'b0;
    logic td = 1'b0;
    ssf_read_req_type rq;
    logic [7:0] fs = 8'h00;
    logic [7:0] rdata, st, ex;
    logic rv;
    logic [7:0] q[$];
    logic [31:0] seed = 32'h14;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2.5 clock_i = ~clock_i;
    ssf_status u_dut (.clock_i(clock_i), .rst_i(rst_i), .fifo_mode_i(md),
        .event_cfg_i(cfg), .press_done_i(pd), .temp_done_i(td), .read_req_i(rq),
        .fifo_status_i(fs), .rdata_o(rdata), .rvalid_o(rv), .sample_status_o(st));
    ssf_host_model u_host (.clock_i(clock_i), .read_req_o(rq));
    // Xorshift source
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wchk();
        repeat (2) @(negedge clock_i);
        chk("status", ex, st);
    endtask
    // Pulse acquisitions and predict the flags
    task automatic evt(logic p, logic t);
        if (p && cfg.press_event_gen_enable) ex = ex | 8'h04 | {1'b0, ex[2], 6'h00};
        if (t && cfg.temp_event_gen_enable) ex = ex | 8'h02 | {2'h0, ex[1], 5'h00};
        if ((p || t) && cfg.ready_event_gen_enable) ex = ex | 8'h08 | {ex[3], 7'h00};
        pd = p;
        td = t;
        @(negedge clock_i);
        pd = 1'b0;
        td = 1'b0;
        wchk();
    endtask
    // Host read with predicted data and clearing
    task automatic rd(logic [7:0] a);
        logic [7:0] d;
        d = (a == SSF_ADDR_STATUS || a == SSF_ADDR_ALIAS) ? ex : 8'h00;
        if (a == SSF_ADDR_ALIAS && md != SSF_FIFO_OFF) d = fs;
        q.push_back(d);
        if (md != SSF_FIFO_OFF) ex = (a == SSF_ADDR_FIFO_DATA) ? 8'h00 : ex;
        else if (a == SSF_ADDR_PRESS_HI) ex = ex & 8'h33;
        else if (a == SSF_ADDR_TEMP_HI) ex = ex & 8'h55;
        u_host.read_byte(a);
        wchk();
    endtask
    // Answer checker and run bound, sampled where outputs are settled
    always @(negedge clock_i) begin
        cyc++;
        if (rv === 1'b1) chk("rdata", q.size() ? q.pop_front() : 8'hEE, rdata);
        if (cyc == 3000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        ex = 8'h00;
        repeat (8) @(negedge clock_i);
        rst_i = 1'b0;
        chk("reset", 8'h00, st);
        chk("reset rdata", 8'h00, rdata);
        chk("reset rvalid", 8'h00, {7'h00, rv});
        for (int m = 0; m < 4; m++) begin
            md = ssf_fifo_mode_type'(m);
            fs = rnd();
            evt(1'b1, 1'b0);
            evt(1'b1, 1'b1);
            rd(SSF_ADDR_ALIAS);
            rd(SSF_ADDR_STATUS);
            rd(SSF_ADDR_PRESS_HI);
            rd(SSF_ADDR_TEMP_HI);
            rd(SSF_ADDR_FIFO_DATA);
        end
        $display("test modes done");
        md = SSF_FIFO_OFF;
        for (int i = 0; i < 6; i++) begin
            cfg = 3'(rnd());
            evt(1'b1, 1'b1);
            evt(1'b0, 1'b1);
            rd(SSF_ADDR_PRESS_HI);
            rd(SSF_ADDR_TEMP_HI);
        end
        $display("test enables done");
        cfg = 3'h7;
        evt(1'b0, 1'b1);
        pd = 1'b1;
        ex = (ex & 8'h33) | 8'h0C;
        q.push_back(8'h00);
        u_host.read_byte(SSF_ADDR_PRESS_HI);
        pd = 1'b0;
        wchk();
        rst_i = 1'b1;
        @(negedge clock_i);
        rst_i = 1'b0;
        ex = 8'h00;
        chk("mid reset", ex, st);
        rd(8'h22);
        chk("left", 8'h00, 8'(q.size()));
        $display("test overlap done");
        print_verdict();
    end
endmodule
